// ### rtl/buck_ctrl_defines.svh
// Timing and field constants for the dual buck peak-current control block.
// Assumes inclusion by the package and by the control module.
// How it works
// - Peak limit comes from 3-bit range and 9-bit threshold code registers.
// - A new range is applied only once the threshold code has been written.
// - Off time equals 64 times the 5-bit constant divided by the sensed coil voltage.
// - Comparator offset cancelation runs unless disabled; peak alternates per cycle.
// - On reset the factory top-range trim is copied into the 7-bit trim.
// - Peak current is scaled by one plus 0.4 times (trim minus 63)/63.
// - At low LED voltage, zero cross ends the off period.
// - Zero cross also governs low-side switch turn-on and reverse-current turn-off.
// - Low-side turns on only with the high-side gate threshold indication.
// - Over-current periods count up to the count limit plus one.
// - The over-current counter clears when disabled and at each dimming cycle.
// - After the count, channel stays off until its error flag is read.
// - All logic runs on the internal oscillator clock.
// - No register access is served while reset is held.
`ifndef BUCK_CTRL_DEFINES_SVH
`define BUCK_CTRL_DEFINES_SVH
`define RANGE_W 3
`define THR_W 9
`define TOFF_W 5
`define TRIM_W 7
`define OCCNT_W 2
`define VCOIL_W 8
`define TIMER_W 16
`define TRIM_MID 7'h3F
`define TRIM_RESET 7'h3F
`define GAIN_W 20
`define OFF_SCALE 16'h0040
`endif

// ### rtl/buck_ctrl_pkg.sv
// Types shared by the buck control channels.
// Assumes the defines header sits in the include path.
`include "buck_ctrl_defines.svh"
package buck_ctrl_pkg;
  typedef struct packed {
    logic [`RANGE_W-1:0] range_sel;
    logic range_wr;
    logic [`THR_W-1:0] thr_code;
    logic thr_wr;
    logic [`TOFF_W-1:0] toff_const;
    logic cancel_dis;
    logic [`TRIM_W-1:0] trim;
    logic trim_wr;
    logic [`OCCNT_W-1:0] oc_limit;
  } chan_cfg_s;

  typedef struct packed {
    logic peak_trip;
    logic zero_cross;
    logic hs_gate_vt;
    logic led_string_voltage_low;
    logic oc_trip;
    logic [`VCOIL_W-1:0] vcoil;
  } chan_sense_s;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic cancel_phase;
    logic [`RANGE_W-1:0] range_act;
    logic [`THR_W-1:0] thr_act;
    logic [`TRIM_W-1:0] trim_act;
    logic [`GAIN_W-1:0] peak_ref;
    logic oc_error;
  } chan_out_s;

  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF, ST_FAULT} phase_e;
endpackage

// ### rtl/buck_peak_current_control.sv
// Dual buck channel peak-current, off-time and over-current control.
// Assumes comparator inputs arrive asynchronously from the analog core and
// configuration strobes arrive on clk_sys from the serial register logic.
`timescale 1ns/10ps
`include "buck_ctrl_defines.svh"

module buck_chan (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic enable,
  input wire logic dimming_control_input,
  input wire logic error_flag_read,
  input wire logic [`TRIM_W-1:0] factory_top_range_trim,
  input wire buck_ctrl_pkg::chan_cfg_s cfg,
  input wire buck_ctrl_pkg::chan_sense_s sense_raw,
  output buck_ctrl_pkg::chan_out_s out
);
  import buck_ctrl_pkg::*;

  chan_sense_s s1_q, s_q;
  logic dim1_q, dim_q, dim_prev_q;
  phase_e st_q, st_d;
  logic [`TIMER_W-1:0] tmr_q, tmr_d;
  logic [`RANGE_W-1:0] rng_pend_q, rng_pend_d, rng_q, rng_d;
  logic pend_q, pend_d;
  logic [`THR_W-1:0] thr_q, thr_d;
  logic [`TRIM_W-1:0] trim_q, trim_d;
  logic trim_load_q;
  logic [`OCCNT_W:0] occ_q, occ_d;
  logic err_q, err_d, canc_q, canc_d, ls_q, ls_d, hs_d;
  logic oc_seen_q, oc_seen_d;
  logic [`GAIN_W-1:0] peak_q, peak_d;
  logic [`TIMER_W-1:0] off_len;
  logic run, dim_edge, oc_full;

  // Two stages on every analog comparator and on the dimming pin
  always_ff @(posedge clk_sys) begin
    s1_q <= sense_raw;
    s_q <= s1_q;
    dim1_q <= dimming_control_input;
    dim_q <= dim1_q;
    dim_prev_q <= dim_q;
  end

  assign dim_edge = dim_q & ~dim_prev_q;
  assign run = enable & dim_q;
  assign oc_full = (occ_q == ({1'b0, cfg.oc_limit} + 3'h1));

  // Off time inverse to coil voltage
  always_comb begin
    if (s_q.vcoil == '0) begin
      off_len = {`TIMER_W{1'b1}};
    end else begin
      off_len = `TIMER_W'(({11'h000, cfg.toff_const} * `OFF_SCALE)
                / {8'h00, s_q.vcoil});
    end
  end

  // Configuration path: range, threshold and trim
  always_comb begin
    rng_pend_d = rng_pend_q;
    pend_d = pend_q;
    rng_d = rng_q;
    thr_d = thr_q;
    trim_d = trim_q;
    if (cfg.range_wr) begin
      rng_pend_d = cfg.range_sel;
      pend_d = 1'b1;
    end
    if (cfg.thr_wr) begin
      thr_d = cfg.thr_code;
      if (pend_q) begin
        rng_d = rng_pend_q;
        pend_d = cfg.range_wr;
      end
    end
    if (cfg.trim_wr) begin
      trim_d = cfg.trim;
    end
    if (trim_load_q) begin
      trim_d = factory_top_range_trim;
    end
  end

  // Gain = thr * (63 + 0.4*(trim-63)), scaled by 5
  always_comb begin
    peak_d = `GAIN_W'({1'b0, thr_q} * `GAIN_W'(5 * 63 + 2 *
             ($signed({1'b0, trim_q}) - $signed({1'b0, `TRIM_MID}))));
  end

  // Switching phase, over-current and low-side control
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    occ_d = occ_q;
    err_d = err_q;
    canc_d = canc_q;
    ls_d = 1'b0;
    oc_seen_d = oc_seen_q;
    case (st_q)
      ST_IDLE: begin
        if (run) begin
          st_d = ST_ON;
        end
      end
      ST_ON: begin
        if (s_q.oc_trip) begin
          oc_seen_d = 1'b1;
        end
        if (s_q.peak_trip) begin
          st_d = ST_OFF;
          tmr_d = off_len;
          canc_d = cfg.cancel_dis ? 1'b0 : ~canc_q;
          if (oc_seen_d && !oc_full) begin
            occ_d = occ_q + 3'h1;
          end
          oc_seen_d = 1'b0;
        end
      end
      ST_OFF: begin
        ls_d = s_q.hs_gate_vt & ~s_q.zero_cross & ~s_q.led_string_voltage_low;
        if (tmr_q != '0) begin
          tmr_d = tmr_q - 1'b1;
        end
        if ((s_q.led_string_voltage_low && s_q.zero_cross) || tmr_q == '0) begin
          st_d = ST_ON;
          ls_d = 1'b0;
        end
      end
      default: begin
        if (error_flag_read) begin
          err_d = 1'b0;
          occ_d = '0;
          st_d = ST_IDLE;
        end
      end
    endcase
    if (st_q != ST_FAULT && oc_full) begin
      st_d = ST_FAULT;
      err_d = 1'b1;
      ls_d = 1'b0;
    end else if (st_q != ST_FAULT && !run) begin
      st_d = ST_IDLE;
      ls_d = 1'b0;
    end
    // Clear counter on disable or dim
    if (!enable || dim_edge) begin
      occ_d = '0;
      oc_seen_d = 1'b0;
    end
  end

  assign hs_d = (st_d == ST_ON);


  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      rng_pend_q <= '0;
      pend_q <= 1'b0;
      rng_q <= '0;
      thr_q <= '0;
      trim_q <= `TRIM_RESET;
      trim_load_q <= 1'b1;
      occ_q <= '0;
      err_q <= 1'b0;
      canc_q <= 1'b0;
      ls_q <= 1'b0;
      oc_seen_q <= 1'b0;
      peak_q <= '0;
      out <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      rng_pend_q <= rng_pend_d;
      pend_q <= pend_d;
      rng_q <= rng_d;
      thr_q <= thr_d;
      trim_q <= trim_d;
      trim_load_q <= 1'b0;
      occ_q <= occ_d;
      err_q <= err_d;
      canc_q <= canc_d;
      ls_q <= ls_d;
      oc_seen_q <= oc_seen_d;
      peak_q <= peak_d;
      out.hs_on <= hs_d;
      out.ls_on <= ls_d;
      out.cancel_phase <= canc_d;
      out.range_act <= rng_d;
      out.thr_act <= thr_d;
      out.trim_act <= trim_d;
      out.peak_ref <= peak_q;
      out.oc_error <= err_d;
    end
  end

  sequence fault_entry_s;
    st_q != ST_FAULT && st_d == ST_FAULT;
  endsequence

  range_wait_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      (rng_q != $past(rng_q)) |-> $past(cfg.thr_wr))
    else $error("range applied without threshold write");
  trim_reset_a:
    assert property (@(posedge clk_sys) $fell(trim_load_q) |->
      trim_q == $past(factory_top_range_trim))
    else $error("factory trim not loaded after reset");
  ls_gate_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      $rose(out.ls_on) |-> $past(s_q.hs_gate_vt))
    else $error("low side on without gate threshold");
  hs_trip_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      (st_q == ST_ON && s_q.peak_trip) |=> !out.hs_on)
    else $error("high side not off after peak trip");
  oc_hold_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      fault_entry_s |=> (!out.hs_on && out.oc_error) until error_flag_read)
    else $error("channel not held off during fault");
  oc_clear_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      !enable |=> occ_q == '0)
    else $error("counter not cleared on disable");
  oc_count_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      fault_entry_s |-> occ_q == {1'b0, cfg.oc_limit} + 3'h1)
    else $error("fault entered at wrong count");
  zc_end_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      (st_q == ST_OFF && s_q.led_string_voltage_low && s_q.zero_cross && run
       && !oc_full) |=> st_q == ST_ON)
    else $error("zero cross did not end off time");
  cancel_dis_a:
    assert property (@(posedge clk_sys) disable iff (srst)
      (cfg.cancel_dis && st_q == ST_ON && s_q.peak_trip) |=> !canc_q)
    else $error("cancelation active while disabled");
endmodule

module buck_peak_current_control (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [1:0] chan_enable,
  input wire logic [1:0] dimming_control_input,
  input wire logic [1:0] error_flag_read,
  input wire logic [`TRIM_W-1:0] factory_top_range_trim [2],
  input wire buck_ctrl_pkg::chan_cfg_s cfg [2],
  input wire buck_ctrl_pkg::chan_sense_s sense [2],
  output buck_ctrl_pkg::chan_out_s chan_out [2]
);
  import buck_ctrl_pkg::*;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    buck_chan u_ch (
      .clk_sys(clk_sys),
      .srst(srst),
      .enable(chan_enable[i]),
      .dimming_control_input(dimming_control_input[i]),
      .error_flag_read(error_flag_read[i]),
      .factory_top_range_trim(factory_top_range_trim[i]),
      .cfg(cfg[i]),
      .sense_raw(sense[i]),
      .out(chan_out[i])
    );
  end
endmodule

// ### tb/buck_mcu_model.sv
// Microcontroller model: configuration strobes and error flag reads.
// Assumes calls from the bench at falling clock edges, after reset.
`timescale 1ns/10ps
module buck_mcu_model (
  input wire logic clk_sys,
  output buck_ctrl_pkg::chan_cfg_s cfg [2],
  output logic [1:0] error_flag_read
);
  import buck_ctrl_pkg::*;
  initial begin
    cfg[0] = '0;
    cfg[1] = '0;
    error_flag_read = 2'h0;
  end
  task automatic put(inout chan_cfg_s c);
    cfg[0] = c;
    @(negedge clk_sys);
    c.range_wr = 1'b0;
    c.thr_wr = 1'b0;
    c.trim_wr = 1'b0;
    cfg[0] = c;
  endtask
  function automatic logic [6:0] trim_of(logic [6:0] b, logic [3:0] d);
    return b + {{3{d[3]}}, d};
  endfunction
  // Hot trim plus linear and quadratic temperature terms
  // Rounds half up, so only valid while the correction stays positive
  function automatic logic [6:0] temp_trim(logic [6:0] hot, real kl,
                                           int tj);
    real dt;
    dt = tj - 155;
    return hot + 7'($rtoi(kl * dt + 1.2e-4 * dt * dt + 0.5));
  endfunction
  task automatic read_flag();
    error_flag_read = 2'h1;
    @(negedge clk_sys);
    error_flag_read = 2'h0;
  endtask
endmodule

// ### tb/buck_peak_current_control_bench.sv
// Self-checking bench for the dual buck control, channel 0 exercised.
// Assumes the design package and defines header are compiled first.
`timescale 1ns/10ps
`include "buck_ctrl_defines.svh"
module buck_peak_current_control_bench;
  import buck_ctrl_pkg::*;
  logic clk_sys, srst;
  logic [1:0] chan_enable, dimming_control_input, error_flag_read;
  logic [`TRIM_W-1:0] factory_top_range_trim [2];
  chan_cfg_s cfg [2];
  chan_sense_s sense [2];
  chan_out_s chan_out [2];
  chan_cfg_s c;
  int n_mismatch, n_compared;
  buck_mcu_model m (.clk_sys(clk_sys), .cfg(cfg),
    .error_flag_read(error_flag_read));
  buck_peak_current_control dut (.clk_sys(clk_sys), .srst(srst),
    .chan_enable(chan_enable),
    .dimming_control_input(dimming_control_input),
    .error_flag_read(error_flag_read),
    .factory_top_range_trim(factory_top_range_trim),
    .cfg(cfg), .sense(sense), .chan_out(chan_out));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Bounded wait, so a stuck switch shows as a mismatch, not a hang
  task automatic wait_hs(logic v);
    for (int i = 0; i < 60 && chan_out[0].hs_on !== v; i++) cyc(1);
    chk("hs_on", chan_out[0].hs_on, v);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Off time must be timed here: low LED voltage with zero cross would end it at once
  task automatic oc_period(logic e);
    sense[0].oc_trip = 1'b1;
    sense[0].peak_trip = 1'b1;
    wait_hs(1'b0);
    cyc(4);
    chk("oc_error", chan_out[0].oc_error, e);
    sense[0].peak_trip = 1'b0;
    sense[0].oc_trip = 1'b0;
  endtask
  // Off period counted from high side off to high side back on
  task automatic off_len_chk(logic [7:0] vc, logic cp);
    int n;
    sense[0].vcoil = vc;
    cyc(3);
    sense[0].peak_trip = 1'b1;
    wait_hs(1'b0);
    sense[0].peak_trip = 1'b0;
    chk("cancel", chan_out[0].cancel_phase, cp);
    n = 0;
    while (chan_out[0].hs_on !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("off len", n, 5'h1F * `OFF_SCALE / vc + 1);
  endtask
  task automatic t_reset();
    cyc(12);
    chk("rst hs", chan_out[0].hs_on, 1'b0);
    srst = 1'b0;
    cyc(3);
    chk("trim0", chan_out[0].trim_act, 7'h2A);
    chk("trim1", chan_out[1].trim_act, 7'h55);
  endtask
  task automatic t_rereset();
    srst = 1'b1;
    cyc(12);
    srst = 1'b0;
    cyc(3);
    chk("trim again", chan_out[0].trim_act, 7'h2A);
    chk("range rst", chan_out[0].range_act, 3'h0);
    chk("oc rst", chan_out[0].oc_error, 1'b0);
  endtask
  task automatic t_range();
    c = '0;
    c.range_sel = 3'h5;
    c.range_wr = 1'b1;
    m.put(c);
    cyc(3);
    chk("range held", chan_out[0].range_act, 3'h0);
    c.thr_code = 9'h1A5;
    c.thr_wr = 1'b1;
    m.put(c);
    cyc(2);
    chk("range", chan_out[0].range_act, 3'h5);
    chk("thr", chan_out[0].thr_act, 9'h1A5);
    chk("ref", chan_out[0].peak_ref, 'h1A5 * (315 + 2 * ('h2A - 63)));
    c.trim = m.trim_of(7'h2A, 4'h8);
    c.trim_wr = 1'b1;
    m.put(c);
    cyc(2);
    chk("trim", chan_out[0].trim_act, 7'h22);
    chk("ref trim", chan_out[0].peak_ref, 'h1A5 * (315 + 2 * ('h22 - 63)));
    c.trim = m.temp_trim(7'h22, 0.0, 55);
    c.trim_wr = 1'b1;
    m.put(c);
    cyc(2);
    chk("trim temp", chan_out[0].trim_act, 7'h23);
  endtask
  task automatic t_switch();
    c.toff_const = 5'h1F;
    c.oc_limit = 2'h1;
    m.put(c);
    sense[0].vcoil = 8'h01;
    chan_enable = 2'h1;
    dimming_control_input = 2'h1;
    wait_hs(1'b1);
    sense[0].peak_trip = 1'b1;
    wait_hs(1'b0);
    chk("cancel", chan_out[0].cancel_phase, 1'b1);
    cyc(4);
    chk("ls no vt", chan_out[0].ls_on, 1'b0);
    sense[0].hs_gate_vt = 1'b1;
    cyc(4);
    chk("ls vt", chan_out[0].ls_on, 1'b1);
    sense[0].zero_cross = 1'b1;
    cyc(4);
    chk("ls zc", chan_out[0].ls_on, 1'b0);
    chk("hs off", chan_out[0].hs_on, 1'b0);
    sense[0].led_string_voltage_low = 1'b1;
    sense[0].peak_trip = 1'b0;
    wait_hs(1'b1);
    chk("ch1 idle", chan_out[1].hs_on, 1'b0);
  endtask
  task automatic t_toff();
    sense[0].led_string_voltage_low = 1'b0;
    sense[0].zero_cross = 1'b0;
    off_len_chk(8'h40, 1'b0);
    c.cancel_dis = 1'b1;
    m.put(c);
    off_len_chk(8'h20, 1'b0);
    c.cancel_dis = 1'b0;
    m.put(c);
  endtask
  task automatic t_oc();
    sense[0].vcoil = 8'h40;
    cyc(3);
    oc_period(1'b0);
    wait_hs(1'b1);
    oc_period(1'b1);
    cyc(80);
    chk("fault hs", chan_out[0].hs_on, 1'b0);
    chk("fault ls", chan_out[0].ls_on, 1'b0);
    m.read_flag();
    wait_hs(1'b1);
    chk("oc clr", chan_out[0].oc_error, 1'b0);
    oc_period(1'b0);
    wait_hs(1'b1);
    // One dimming cycle on the input
    dimming_control_input = 2'h0;
    cyc(6);
    dimming_control_input = 2'h1;
    wait_hs(1'b1);
    oc_period(1'b0);
    wait_hs(1'b1);
    chan_enable = 2'h0;
    cyc(6);
    chan_enable = 2'h1;
    wait_hs(1'b1);
    oc_period(1'b0);
    wait_hs(1'b1);
    oc_period(1'b1);
  endtask
  initial begin
    srst = 1'b1;
    chan_enable = 2'h0;
    dimming_control_input = 2'h0;
    factory_top_range_trim[0] = 7'h2A;
    factory_top_range_trim[1] = 7'h55;
    sense[0] = '0;
    sense[1] = '0;
    t_reset();
    t_range();
    t_switch();
    t_toff();
    t_oc();
    t_rereset();
    wrap_up();
  end
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule
